// ---- shared/sfm_cfg.svh ----
`ifndef SFM_CFG_SVH
`define SFM_CFG_SVH

// Clock rate and half-second time base
`define SFM_CLK_KHZ       20000
`define SFM_HALF_SEC_MS   500
`define SFM_HALF_SEC_CYC  (`SFM_HALF_SEC_MS * `SFM_CLK_KHZ)

// Signal space sizes
`define SFM_NUM_SYS_BITS  24
`define SFM_IN_LIM_LARGE  5'h0f
`define SFM_IN_LIM_SMALL  5'h06
`define SFM_AN_LIM_LARGE  4'h8
`define SFM_AN_LIM_SMALL  4'h6

// Analog scaling: 0..10 V gives 0..500, 20 mV per step
`define SFM_MV_PER_STEP   14'h0014
`define SFM_ANALOG_MAX    14'h01f4

// Reset values of the constant bits
`define SFM_CONST_HIGH_RST 1'b1
`define SFM_CONST_LOW_RST  1'b0

`endif

// ---- shared/sfm_pkg.sv ----
package sfm_pkg;
  typedef logic [8:0] sfm_analog_t;
  typedef enum logic [1:0] {
    SFM_FREE,
    SFM_FORCE_ON,
    SFM_FORCE_OFF
  } sfm_force_e;
endpackage

// ---- src/sfm_sync3.sv ----
module sfm_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_d;

  // Bit follows only once the last two stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= q_d;
    end
  end
endmodule

// ---- src/sfm_top.sv ----
// How it works
// - Twenty-four numbered system bits readable by program
// - First bit always high, second always low
// - Third bit toggles every half second
// - Clock error flag while clock data invalid
// - Daylight flag while summer time active
// - Large models flag fieldbus communication error
// - Large models flag fieldbus power loss error
// - Run entry pulses one bit high, one low
// - Decoding flag held during radio time decoding
// - One success pulse after error-free decode
// - Failure flag set when decode ends erroneously
// - Large models mirror modem carrier detect
// - Large models flag cellular network available
// - Large models flag remote cellular access
// - Large models flag analog board power present
// - Eight sensor defect flags on large models, six on small, one per input
// - Eight front keys exposed as program signals
// - Program-wired keys stop navigating the display
// - Confirm key forces selected input in monitor
// - Large models offer fifteen digital inputs
// - Large DC models offer eight analog values
// - Smallest DC model offers six analog values
// - Zero to ten volts maps to 0..500
`include "sfm_cfg.svh"

module sfm_top #(
  parameter int HALF_SEC_CYCLES = `SFM_HALF_SEC_CYC
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Model configuration
  input  wire logic                     model_large,
  input  wire logic                     model_dc,
  // Physical pins
  input  wire logic [14:0]              pin_inputs,
  input  wire logic [7:0]               pin_keys,
  input  wire logic                     pin_modem_dcd,
  // On-chip status sources
  input  wire logic                     rtc_data_invalid,
  input  wire logic                     summer_time_active,
  input  wire logic                     asi_comm_error,
  input  wire logic                     asi_power_error,
  input  wire logic                     radio_decoding,
  input  wire logic                     radio_done,
  input  wire logic                     radio_error,
  input  wire logic                     cell_network_ok,
  input  wire logic                     cell_remote_session,
  input  wire logic                     dac_ext_power,
  input  wire logic [7:0]               sensor_defect,
  // Program scan
  input  wire logic                     run_mode,
  input  wire logic                     scan_start,
  // Monitor and key use
  input  wire logic                     monitor_active,
  input  wire logic [3:0]               monitor_select,
  input  wire logic [7:0]               key_aux_mask,
  // Analog conversion
  input  wire logic                     adc_valid,
  input  wire logic [2:0]               adc_channel,
  input  wire logic [13:0]              adc_millivolts,
  // System bits
  output logic [23:0]                   sys_bits,
  output logic                          flag_const_high,
  output logic                          flag_const_low,
  output logic                          flag_half_second_toggle,
  output logic                          flag_clock_data_error,
  output logic                          flag_daylight_saving,
  output logic                          flag_fieldbus_comm_error,
  output logic                          flag_fieldbus_power_fail,
  output logic                          pulse_high_on_run_entry,
  output logic                          pulse_low_on_run_entry,
  output logic                          flag_radio_time_decoding,
  output logic                          pulse_radio_decode_ok,
  output logic                          flag_modem_carrier,
  output logic                          flag_cell_network_up,
  output logic                          flag_cell_remote_access,
  output logic                          flag_radio_decode_fail,
  output logic                          flag_dac_board_powered,
  output logic [7:0]                    flag_sensor_defect,
  // Program inputs
  output logic [14:0]                   input_values,
  output logic [7:0]                    key_prog,
  output logic [7:0]                    key_nav,
  output sfm_pkg::sfm_analog_t [7:0]    analog_values
);
  import sfm_pkg::*;

  localparam logic [23:0] HALF_LAST = 24'(HALF_SEC_CYCLES - 1);

  // Reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Pin synchronisers
  logic [23:0] pins_s;
  logic [14:0] in_s;
  logic [7:0]  key_s;
  logic        dcd_s;

  sfm_sync3 #(.W(24)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({pin_modem_dcd, pin_keys, pin_inputs}),
    .q     (pins_s)
  );
  assign in_s  = pins_s[14:0];
  assign key_s = pins_s[22:15];
  assign dcd_s = pins_s[23];

  // Half-second time base
  logic [23:0] half_cnt_q;
  logic [23:0] half_cnt_d;
  logic        toggle_d;

  always_comb begin
    half_cnt_d = half_cnt_q + 24'h00_0001;
    toggle_d   = flag_half_second_toggle;
    if (half_cnt_q >= HALF_LAST) begin
      half_cnt_d = 24'h00_0000;
      toggle_d   = ~flag_half_second_toggle;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_q              <= 24'h00_0000;
      flag_half_second_toggle <= 1'b0;
    end else begin
      half_cnt_q              <= half_cnt_d;
      flag_half_second_toggle <= toggle_d;
    end
  end

  // Scan-aligned pulses; pending events survive a same-cycle scan clear
  logic run_q;
  logic run_pend_q;
  logic run_pend_d;
  logic ok_pend_q;
  logic ok_pend_d;
  logic run_rise;
  logic ok_evt;
  logic pulse_hi_d;
  logic ok_pulse_d;

  assign run_rise = run_mode & ~run_q;
  assign ok_evt   = radio_done & ~radio_error;

  always_comb begin
    run_pend_d = run_pend_q | run_rise;
    ok_pend_d  = ok_pend_q | ok_evt;
    pulse_hi_d = pulse_high_on_run_entry;
    ok_pulse_d = pulse_radio_decode_ok;
    if (scan_start) begin
      pulse_hi_d = run_pend_q | run_rise;
      ok_pulse_d = ok_pend_q | ok_evt;
      run_pend_d = 1'b0;
      ok_pend_d  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q                   <= 1'b0;
      run_pend_q              <= 1'b0;
      ok_pend_q               <= 1'b0;
      pulse_high_on_run_entry <= 1'b0;
      pulse_low_on_run_entry  <= 1'b1;
      pulse_radio_decode_ok   <= 1'b0;
    end else begin
      run_q                   <= run_mode;
      run_pend_q              <= run_pend_d;
      ok_pend_q               <= ok_pend_d;
      pulse_high_on_run_entry <= pulse_hi_d;
      pulse_low_on_run_entry  <= ~pulse_hi_d;
      pulse_radio_decode_ok   <= ok_pulse_d;
    end
  end

  // Level flags; fail holds until the next decode starts
  logic       fail_d;
  logic [7:0] defect_d;
  logic       rtc_d;
  logic       dst_d;
  logic       asi_err_d;
  logic       asi_pwr_d;
  logic       dcd_d;
  logic       net_d;
  logic       remote_d;
  logic       dac_d;

  always_comb begin
    rtc_d     = rtc_data_invalid;
    dst_d     = summer_time_active;
    asi_err_d = model_large & asi_comm_error;
    asi_pwr_d = model_large & asi_power_error;
    dcd_d     = model_large & dcd_s;
    net_d     = model_large & cell_network_ok;
    remote_d  = model_large & cell_remote_session;
    dac_d     = model_large & dac_ext_power;
    defect_d  = model_large ? sensor_defect : {2'h0, sensor_defect[5:0]};
    fail_d    = flag_radio_decode_fail;
    if (radio_decoding) begin
      fail_d = 1'b0;
    end
    if (radio_done & radio_error) begin
      fail_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_const_high          <= `SFM_CONST_HIGH_RST;
      flag_const_low           <= `SFM_CONST_LOW_RST;
      flag_clock_data_error    <= 1'b0;
      flag_daylight_saving     <= 1'b0;
      flag_fieldbus_comm_error <= 1'b0;
      flag_fieldbus_power_fail <= 1'b0;
      flag_radio_time_decoding <= 1'b0;
      flag_radio_decode_fail   <= 1'b0;
      flag_modem_carrier       <= 1'b0;
      flag_cell_network_up     <= 1'b0;
      flag_cell_remote_access  <= 1'b0;
      flag_dac_board_powered   <= 1'b0;
      flag_sensor_defect       <= 8'h00;
    end else begin
      flag_const_high          <= 1'b1;
      flag_const_low           <= 1'b0;
      flag_clock_data_error    <= rtc_d;
      flag_daylight_saving     <= dst_d;
      flag_fieldbus_comm_error <= asi_err_d;
      flag_fieldbus_power_fail <= asi_pwr_d;
      flag_radio_time_decoding <= radio_decoding;
      flag_radio_decode_fail   <= fail_d;
      flag_modem_carrier       <= dcd_d;
      flag_cell_network_up     <= net_d;
      flag_cell_remote_access  <= remote_d;
      flag_dac_board_powered   <= dac_d;
      flag_sensor_defect       <= defect_d;
    end
  end

  // Numbered system bit image, bit 0 is the first bit
  logic [23:0] sys_bits_d;

  always_comb begin
    sys_bits_d = {defect_d, dac_d, fail_d, remote_d, net_d, dcd_d, ok_pulse_d, radio_decoding,
                  ~pulse_hi_d, pulse_hi_d, asi_pwr_d, asi_err_d, dst_d, rtc_d, toggle_d, 1'b0, 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_bits <= 24'h00_0101;
    end else begin
      sys_bits <= sys_bits_d;
    end
  end

  // Keys and monitor forcing
  sfm_force_e  force_q [15];
  sfm_force_e  force_d [15];
  logic        conf_prev_q;
  logic [7:0]  nav_d;
  logic [7:0]  prog_d;
  logic [4:0]  in_lim;
  logic [14:0] in_d;
  logic        conf_edge;

  assign in_lim    = model_large ? `SFM_IN_LIM_LARGE : `SFM_IN_LIM_SMALL;
  assign nav_d     = key_s & ~key_aux_mask;
  assign prog_d    = key_s & key_aux_mask;
  assign conf_edge = nav_d[0] & ~conf_prev_q;

  always_comb begin
    for (int i = 0; i < 15; i++) begin
      force_d[i] = force_q[i];
      if (!monitor_active || (5'(i) >= in_lim)) begin
        force_d[i] = SFM_FREE;
      end else if (conf_edge && (monitor_select == 4'(i))) begin
        unique case (force_q[i])
          SFM_FREE:      force_d[i] = SFM_FORCE_ON;
          SFM_FORCE_ON:  force_d[i] = SFM_FORCE_OFF;
          SFM_FORCE_OFF: force_d[i] = SFM_FORCE_ON;
          default:       force_d[i] = SFM_FREE;
        endcase
      end
      in_d[i] = (5'(i) < in_lim) & in_s[i];
      if (force_d[i] == SFM_FORCE_ON) begin
        in_d[i] = 1'b1;
      end else if (force_d[i] == SFM_FORCE_OFF) begin
        in_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 15; i++) begin
        force_q[i] <= SFM_FREE;
      end
      conf_prev_q  <= 1'b0;
      input_values <= 15'h0000;
      key_prog     <= 8'h00;
      key_nav      <= 8'h00;
    end else begin
      force_q      <= force_d;
      conf_prev_q  <= nav_d[0];
      input_values <= in_d;
      key_prog     <= prog_d;
      key_nav      <= nav_d;
    end
  end

  // Analog values; division by a constant keeps it to one cycle
  logic [13:0] adc_steps;
  sfm_analog_t adc_scaled;
  logic [3:0]  an_lim;
  sfm_analog_t [7:0] an_d;

  assign adc_steps  = adc_millivolts / `SFM_MV_PER_STEP;
  assign adc_scaled = (adc_steps > `SFM_ANALOG_MAX) ? 9'(`SFM_ANALOG_MAX) : adc_steps[8:0];
  assign an_lim     = model_large ? `SFM_AN_LIM_LARGE : `SFM_AN_LIM_SMALL;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      an_d[i] = analog_values[i];
      if (!model_dc || (4'(i) >= an_lim)) begin
        an_d[i] = 9'h000;
      end else if (adc_valid && (adc_channel == 3'(i))) begin
        an_d[i] = adc_scaled;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_values <= '0;
    end else begin
      analog_values <= an_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_const_bits;
    flag_const_high && !flag_const_low && sys_bits[0] && !sys_bits[1];
  endproperty
  a_const_bits: assert property (p_const_bits) else $error("constant bits wrong");

  property p_toggle_period;
    $changed(flag_half_second_toggle) |-> $past(half_cnt_q) == HALF_LAST;
  endproperty
  a_toggle_period: assert property (p_toggle_period) else $error("toggle off period");

  property p_run_pair;
    pulse_low_on_run_entry == !pulse_high_on_run_entry && sys_bits[8] != sys_bits[7];
  endproperty
  a_run_pair: assert property (p_run_pair) else $error("run pulses not complementary");

  property p_pulse_scan;
    $changed(pulse_high_on_run_entry) || $changed(pulse_radio_decode_ok) |-> $past(scan_start);
  endproperty
  a_pulse_scan: assert property (p_pulse_scan) else $error("pulse moved off a scan edge");

  property p_ok_pulse;
    ok_evt && scan_start |=> pulse_radio_decode_ok;
  endproperty
  a_ok_pulse: assert property (p_ok_pulse) else $error("decode success pulse missing");

  property p_fail_flag;
    radio_done && radio_error |=> flag_radio_decode_fail && sys_bits[14];
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("decode failure not flagged");

  property p_small_model;
    !model_large ##1 !model_large |-> !flag_modem_carrier && !flag_cell_network_up && input_values[14:6] == 9'h000;
  endproperty
  a_small_model: assert property (p_small_model) else $error("small model shows large features");

  property p_key_split;
    (key_prog & key_nav) == 8'h00;
  endproperty
  a_key_split: assert property (p_key_split) else $error("key both program and navigation");

  property p_analog_range;
    adc_valid && model_dc && adc_channel < 3'h6 |=> analog_values[$past(adc_channel)] <= 9'h1f4;
  endproperty
  a_analog_range: assert property (p_analog_range) else $error("analog value above range");
endmodule

// ---- tb/sfm_scan_model.sv ----
module sfm_scan_model #(
  parameter int SCAN_CYC = 6
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Scan boundary
  output logic      scan_start
);
  timeunit 1ns;
  timeprecision 1ns;

  int cnt_q;

  // Steady scan rate, so pulse lengths are predictable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q      <= 0;
      scan_start <= 1'b0;
    end else begin
      cnt_q      <= (cnt_q == SCAN_CYC - 1) ? 0 : cnt_q + 1;
      scan_start <= (cnt_q == SCAN_CYC - 1);
    end
  end
endmodule

// ---- tb/tb_sfm_top.sv ----
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb_sfm_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int HALF = 8;
  localparam int SCAN = 6;

  logic clk, resetn, model_large, model_dc, pin_modem_dcd, rtc_data_invalid, summer_time_active;
  logic asi_comm_error, asi_power_error, radio_decoding, radio_done, radio_error, cell_network_ok;
  logic cell_remote_session, dac_ext_power, run_mode, scan_start, monitor_active, adc_valid;
  logic [14:0] pin_inputs;
  logic [7:0]  pin_keys, sensor_defect, key_aux_mask;
  logic [3:0]  monitor_select;
  logic [2:0]  adc_channel;
  logic [13:0] adc_millivolts;
  logic [23:0] sys_bits;
  logic flag_const_high, flag_const_low, flag_half_second_toggle, flag_clock_data_error;
  logic flag_daylight_saving, flag_fieldbus_comm_error, flag_fieldbus_power_fail;
  logic pulse_high_on_run_entry, pulse_low_on_run_entry, flag_radio_time_decoding;
  logic pulse_radio_decode_ok, flag_modem_carrier, flag_cell_network_up, flag_cell_remote_access;
  logic flag_radio_decode_fail, flag_dac_board_powered;
  logic [7:0]  flag_sensor_defect, key_prog, key_nav;
  logic [14:0] input_values;
  sfm_pkg::sfm_analog_t [7:0] analog_values;
  int checked, n_fail, cycles, n;

  sfm_top #(.HALF_SEC_CYCLES(HALF)) dut (
    .clk, .resetn, .model_large, .model_dc, .pin_inputs, .pin_keys, .pin_modem_dcd,
    .rtc_data_invalid, .summer_time_active, .asi_comm_error, .asi_power_error, .radio_decoding,
    .radio_done, .radio_error, .cell_network_ok, .cell_remote_session, .dac_ext_power,
    .sensor_defect, .run_mode, .scan_start, .monitor_active, .monitor_select, .key_aux_mask,
    .adc_valid, .adc_channel, .adc_millivolts, .sys_bits, .flag_const_high, .flag_const_low,
    .flag_half_second_toggle, .flag_clock_data_error, .flag_daylight_saving,
    .flag_fieldbus_comm_error, .flag_fieldbus_power_fail, .pulse_high_on_run_entry,
    .pulse_low_on_run_entry, .flag_radio_time_decoding, .pulse_radio_decode_ok,
    .flag_modem_carrier, .flag_cell_network_up, .flag_cell_remote_access,
    .flag_radio_decode_fail, .flag_dac_board_powered, .flag_sensor_defect, .input_values,
    .key_prog, .key_nav, .analog_values
  );

  sfm_scan_model #(.SCAN_CYC(SCAN)) prog (.clk(clk), .resetn(resetn), .scan_start(scan_start));

  always #25 clk = ~clk;

  task automatic tally_and_finish();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Hang guard, several times the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask

  function automatic logic hi(input int sel);
    return sel ? pulse_radio_decode_ok : pulse_high_on_run_entry;
  endfunction

  // Waits for a pulse and returns how many cycles it stood
  task automatic pulse_len(input int sel, output int len);
    int w;
    len = 0;
    w = 0;
    while (hi(sel) !== 1'b1 && w < 50) begin
      tick(1);
      w++;
    end
    if (sel == 0) `CHK({pulse_low_on_run_entry, sys_bits[8:7]}, 3'b001)
    else `CHK(sys_bits[10], 1'b1)
    while (hi(sel) === 1'b1 && len < 50) begin
      tick(1);
      len++;
    end
  endtask

  // Toggle changes seen at one-cycle resolution
  task automatic toggle_gap(output int gap);
    logic last;
    int w;
    w = 0;
    last = flag_half_second_toggle;
    while (flag_half_second_toggle === last && w < 100) begin
      tick(1);
      w++;
    end
    gap = 0;
    last = flag_half_second_toggle;
    while (flag_half_second_toggle === last && gap < 100) begin
      tick(1);
      gap++;
    end
  endtask

  task automatic press();
    pin_keys[0] = 1'b1;
    tick(8);
    pin_keys[0] = 1'b0;
    tick(8);
  endtask

  task automatic adc(input logic [2:0] ch, input logic [13:0] mv);
    adc_valid = 1'b1;
    adc_channel = ch;
    adc_millivolts = mv;
    tick(1);
    adc_valid = 1'b0;
    tick(2);
  endtask

  initial begin
    clk = 0; resetn = 0; model_large = 1; model_dc = 1; pin_inputs = '0; pin_keys = '0;
    pin_modem_dcd = 0; rtc_data_invalid = 0; summer_time_active = 0; asi_comm_error = 0;
    asi_power_error = 0; radio_decoding = 0; radio_done = 0; radio_error = 0; cell_network_ok = 0;
    cell_remote_session = 0; dac_ext_power = 0; sensor_defect = '0; run_mode = 0;
    monitor_active = 0; monitor_select = '0; key_aux_mask = '0; adc_valid = 0;
    adc_channel = '0; adc_millivolts = '0;
    tick(20);
    `CHK(sys_bits, 24'h00_0101)
    resetn = 1;
    tick(10);
    `CHK({flag_const_high, flag_const_low}, 2'b10)
    toggle_gap(n);
    `CHK(n, HALF)
    `CHK({flag_half_second_toggle, sys_bits[2]}, 2'b11)
    // All status sources but radio on, large model first, then the small one masks
    {rtc_data_invalid, summer_time_active, asi_comm_error, asi_power_error} = 4'hf;
    {cell_network_ok, cell_remote_session, dac_ext_power, pin_modem_dcd} = 4'hf;
    sensor_defect = 8'hff;
    tick(8);
    `CHK(sys_bits & 24'hff_fffb, 24'hff_b979)
    `CHK({flag_modem_carrier, flag_dac_board_powered, flag_sensor_defect}, 10'h3ff)
    `CHK({flag_clock_data_error, flag_daylight_saving}, 2'b11)
    `CHK({flag_fieldbus_comm_error, flag_fieldbus_power_fail}, 2'b11)
    `CHK({flag_cell_network_up, flag_cell_remote_access}, 2'b11)
    model_large = 0;
    tick(2);
    `CHK(sys_bits & 24'hff_fffb, 24'h3f_0119)
    `CHK({flag_fieldbus_comm_error, flag_fieldbus_power_fail, flag_cell_remote_access}, 3'h0)
    `CHK({flag_dac_board_powered, flag_sensor_defect}, 9'h03f)
    model_large = 1;
    {rtc_data_invalid, summer_time_active, asi_comm_error, asi_power_error} = 4'h0;
    tick(2);
    `CHK(sys_bits[6:3], 4'h0)
    `CHK({flag_clock_data_error, flag_daylight_saving}, 2'b00)
    run_mode = 1;
    pulse_len(0, n);
    `CHK(n, SCAN)
    `CHK(pulse_low_on_run_entry, 1'b1)
    radio_decoding = 1;
    // Done lands on a scan edge, so the same-cycle delivery path is taken
    tick(5);
    `CHK({flag_radio_time_decoding, sys_bits[9]}, 2'b11)
    radio_decoding = 0;
    radio_done = 1;
    tick(1);
    radio_done = 0;
    pulse_len(1, n);
    `CHK(n, SCAN)
    `CHK(flag_radio_decode_fail, 1'b0)
    radio_done = 1;
    radio_error = 1;
    tick(1);
    radio_done = 0;
    radio_error = 0;
    tick(2);
    `CHK({flag_radio_decode_fail, sys_bits[14], pulse_radio_decode_ok}, 3'b110)
    radio_decoding = 1;
    tick(2);
    `CHK(flag_radio_decode_fail, 1'b0)
    radio_decoding = 0;
    key_aux_mask = 8'hf0;
    pin_keys = 8'hfe;
    tick(8);
    `CHK({key_prog, key_nav}, 16'hf00e)
    pin_keys = 8'h00;
    pin_inputs = 15'h7fff;
    tick(8);
    `CHK(input_values, 15'h7fff)
    model_large = 0;
    tick(2);
    `CHK(input_values, 15'h003f)
    model_large = 1;
    pin_inputs = 15'h0000;
    monitor_active = 1;
    monitor_select = 4'h3;
    tick(8);
    press();
    `CHK(input_values, 15'h0008)
    // Pin high, so a forced off differs from a free input
    pin_inputs = 15'h0008;
    press();
    `CHK(input_values, 15'h0000)
    pin_inputs = 15'h0000;
    press();
    monitor_select = 4'hf;
    press();
    `CHK(input_values, 15'h0008)
    monitor_active = 0;
    tick(2);
    `CHK(input_values, 15'h0000)
    adc(3'h7, 14'h1388);
    `CHK(analog_values[7], 9'h0fa)
    adc(3'h0, 14'h2710);
    `CHK(analog_values[0], 9'h1f4)
    adc(3'h1, 14'h3fff);
    `CHK(analog_values[1], 9'h1f4)
    adc(3'h2, 14'h0013);
    `CHK(analog_values[2], 9'h000)
    adc(3'h2, 14'h0014);
    `CHK(analog_values[2], 9'h001)
    model_large = 0;
    tick(2);
    `CHK({analog_values[7], analog_values[0]}, 18'h0_01f4)
    model_dc = 0;
    tick(2);
    `CHK(analog_values[0], 9'h000)
    // Second reset in mid-run, Run still selected
    resetn = 0;
    tick(2);
    `CHK({pulse_low_on_run_entry, sys_bits}, 25'h100_0101)
    resetn = 1;
    pulse_len(0, n);
    `CHK(n, SCAN)
    tally_and_finish();
  end
endmodule
